//--- dv/e1li_xcvr_model.sv
// e1li_xcvr_model: line transceiver stand-in driving the receive line side
`timescale 1ns/1ps
`default_nettype none
module e1li_xcvr_model
  import e1li_pkg::*;
(
  input wire logic en, // send bits while high
  input wire e1li_rails_t at_rise, // rails shown around the rising edge
  input wire e1li_rails_t at_fall, // rails shown around the falling edge
  output logic rx_line_clock, // recovered clock, still between bursts
  output e1li_rails_t rails // receive rails
);
  initial
  begin
    rx_line_clock = 1'b0;
    rails = '0;
  end
  // each value stands 40 ns on either side of its edge, above the 30 ns window
  always
  begin
    wait (en === 1'b1);
    rails = at_rise;
    #40;
    rx_line_clock = 1'b1;
    #40;
    rails = at_fall;
    #40;
    rx_line_clock = 1'b0;
    #40;
    // a released line must not keep showing the last value
    if (en !== 1'b1)
      rails = ~rails;
  end
endmodule : e1li_xcvr_model
`default_nettype wire

//--- dv/tb_e1_line_side_interface.sv
// tb_e1_line_side_interface: register, receive and transmit tests of one channel
`timescale 1ns/1ps
`default_nettype none
module tb_e1_line_side_interface
  import e1li_pkg::*;
;
  logic sys_clk = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [15:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic pready, pslverr, irq, err, line_en = 1'b0;
  logic rx_line_clock, tx_line_clock, tx_pos_rail, tx_neg_rail, rx_valid, rx_fs_pulse, tx_bit_req;
  e1li_rails_t line, rx_bit, tx_bit = '0, at_rise = '0, at_fall = '0, last_bit = '0;
  int num_errors = 0, checks_done = 0, fs_seen = 0, cyc;
  realtime t0;
  localparam logic [11:0] RIDX [6] = '{IDX_CTRL1, IDX_CTRL2, IDX_FSYNC, IDX_CVCNT, IDX_STAT, IDX_MASK};
  localparam logic [7:0] REXP [6] = '{CTRL1_RST, CTRL2_RST, FSYNC_RST, 8'h00, 8'h00, 8'h00};

  e1li_line_if e1li_line_if_i (.sys_clk(sys_clk), .resetn(resetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq), .rx_line_clock(rx_line_clock),
    .rx_pos_rail(line.pos), .rx_neg_rail(line.neg), .tx_line_clock(tx_line_clock),
    .tx_pos_rail(tx_pos_rail), .tx_neg_rail(tx_neg_rail), .rx_valid(rx_valid),
    .rx_bit(rx_bit), .rx_fs_pulse(rx_fs_pulse), .tx_bit_req(tx_bit_req), .tx_bit(tx_bit));
  e1li_xcvr_model e1li_xcvr_model_i (.en(line_en), .at_rise(at_rise), .at_fall(at_fall),
    .rx_line_clock(rx_line_clock), .rails(line));

  always #5 sys_clk = ~sys_clk;

  always @(posedge sys_clk)
  begin
    if (rx_valid === 1'b1)
      last_bit <= rx_bit;
    if (rx_fs_pulse === 1'b1)
      fs_seen <= fs_seen + 1;
  end

  // ----------------------------------------------------------------
  // access tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
    begin
      checks_done++;
      if (got !== exp)
      begin
        num_errors++;
        $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
    end
  endtask : check

  function automatic logic [11:0] ch(input logic [11:0] i);
    return {4'h1, i[7:0]};
  endfunction : ch

  task automatic apb(input logic w, input logic [11:0] idx, input logic [31:0] wd);
    begin
      @(posedge sys_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= {2'b00, idx, 2'b00};
      pwdata <= wd;
      @(posedge sys_clk);
      penable <= 1'b1;
      do
        @(posedge sys_clk);
      while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask : apb

  // n line bits, then time for the two-stage synchroniser to drain
  task automatic send(input e1li_rails_t a, input e1li_rails_t b, input int n);
    begin
      @(posedge sys_clk);
      at_rise <= a;
      at_fall <= b;
      line_en <= 1'b1;
      repeat (n) @(negedge rx_line_clock);
      @(posedge sys_clk);
      line_en <= 1'b0;
      repeat (12) @(posedge sys_clk);
    end
  endtask : send

  task automatic txw(input int n);
    int k;
    begin
      repeat (n)
      begin
        k = 0;
        do
        begin
          @(posedge sys_clk);
          k++;
        end
        while (tx_bit_req !== 1'b1 && k < 200);
        if (k >= 200)
        begin
          num_errors++;
          report_and_stop();
        end
      end
    end
  endtask : txw

  task automatic report_and_stop;
    begin
      if (num_errors == 0 && checks_done > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask : report_and_stop

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial
  begin
    #1000000;
    num_errors++;
    report_and_stop();
  end

  initial
  begin
    repeat (12) @(posedge sys_clk);
    resetn <= 1'b1;
    for (int i = 0; i < 6; i++)
    begin
      apb(1'b0, ch(RIDX[i]), 32'h0);
      check("reset value", rd, {24'h0, REXP[i]});
    end
    apb(1'b0, {4'h2, 8'h00}, 32'h0);
    check("other channel", {31'h0, err}, 32'h1);
    apb(1'b1, {4'h2, 8'h00}, 32'h0);
    apb(1'b0, ch(IDX_CTRL1), 32'h0);
    check("foreign write", rd, {24'h0, CTRL1_RST});
    apb(1'b1, ch(IDX_MASK), 32'h1);
    send(2'b10, 2'b01, 2);
    check("rail rx", last_bit, 32'h2);
    send(2'b01, 2'b10, 2);
    check("rail rx", last_bit, 32'h1);
    apb(1'b1, ch(IDX_CTRL2), 32'h80);
    send(2'b10, 2'b01, 2);
    check("falling rx", last_bit, 32'h1);
    apb(1'b0, ch(IDX_CVCNT), 32'h0);
    check("rail cvcnt", rd, 32'h0);
    apb(1'b1, ch(IDX_CTRL1), 32'h0);
    apb(1'b1, ch(IDX_CTRL2), 32'hc0);
    send(2'b10, 2'b00, 2);
    check("nrz rx", last_bit, 32'h2);
    apb(1'b1, ch(IDX_CTRL2), 32'h41);
    send(2'b10, 2'b10, 2);
    check("nrz inv rx", last_bit, 32'h0);
    send(2'b01, 2'b00, 5);
    send(2'b00, 2'b01, 3);
    apb(1'b0, ch(IDX_CVCNT), 32'h0);
    check("cvcnt", rd, 32'h5);
    check("irq set", {31'h0, irq}, 32'h1);
    apb(1'b0, IDX_ISUM, 32'h0);
    check("isum", rd, 32'h1);
    apb(1'b0, ch(IDX_STAT), 32'h0);
    check("stat", rd, 32'h1);
    @(posedge sys_clk);
    check("irq clear", {31'h0, irq}, 32'h0);
    apb(1'b1, ch(IDX_FSYNC), 32'h2);
    send(2'b01, 2'b01, 1);
    send(2'b00, 2'b00, 3);
    check("fs pulses", fs_seen, 32'h1);
    apb(1'b0, ch(IDX_CVCNT), 32'h0);
    check("fs cvcnt", rd, 32'h5);
    apb(1'b0, ch(IDX_STAT), 32'h0);
    check("fs stat", rd, 32'h2);
    apb(1'b1, ch(IDX_FSYNC), 32'h0);
    apb(1'b1, ch(IDX_CTRL1), 32'h80);
    apb(1'b1, ch(IDX_CTRL2), 32'hc0);
    tx_bit <= 2'b10;
    txw(2);
    check("tx rails", {30'h0, tx_pos_rail, tx_neg_rail}, 32'h2);
    check("tx rise", {31'h0, tx_line_clock}, 32'h1);
    tx_bit <= 2'b01;
    txw(2);
    check("tx rails", {30'h0, tx_pos_rail, tx_neg_rail}, 32'h1);
    t0 = $realtime;
    txw(64);
    cyc = int'(($realtime - t0) / 10.0);
    check("tx period", {31'h0, cyc >= 3123 && cyc <= 3127}, 32'h1);
    apb(1'b1, ch(IDX_CTRL2), 32'h40);
    txw(2);
    check("tx fall", {31'h0, tx_line_clock}, 32'h0);
    apb(1'b1, ch(IDX_CTRL1), 32'h40);
    txw(2);
    check("nrz tx", {30'h0, tx_pos_rail, tx_neg_rail}, 32'h3);
    apb(1'b1, ch(IDX_CTRL2), 32'h60);
    tx_bit <= 2'b10;
    txw(2);
    check("nrz inv tx", {31'h0, tx_pos_rail}, 32'h0);
    apb(1'b1, ch(IDX_CTRL1), 32'h00);
    txw(2);
    check("gp low", {31'h0, tx_neg_rail}, 32'h0);
    apb(1'b1, ch(IDX_CTRL1), 32'h40);
    apb(1'b1, ch(IDX_FSYNC), 32'h1);
    txw(3);
    check("fs out idle", {31'h0, tx_neg_rail}, 32'h0);
    report_and_stop();
  end
endmodule : tb_e1_line_side_interface
`default_nettype wire

//--- hdl/e1li_line_if.sv
// e1li_line_if: one channel of the e1 line-side interface with apb registers
//
// Function
// R1 - rail mode set: receive positive rail high marks a positive line pulse
// R2 - rail mode: receive negative rail high marks a negative line pulse
// R3 - rail mode clear: nrz mode, first receive pin carries active-high data
// R4 - receive nrz invert set: receive nrz data taken as active low
// R5 - nrz, rx fast sync off: second pin high bumps 16-bit violation counter
// R6 - external violation sampled on rising receive line clock edges
// R7 - nrz, rx fast sync on: pulse on second pin marks multiframe bit 256
// R8 - receive line clock edge chosen by rx edge bit, one means rising
// R9 - rail mode: transmit positive rail high for each positive pulse
// R10 - rail mode: transmit negative rail high for each negative pulse
// R11 - nrz: transmit data active high, inverted when transmit invert set
// R12 - nrz, tx fast sync off: gp value shifted out on rising tx clock edges
// R13 - nrz, tx fast sync on: pulse every 2 ms at multiframe bit 256
// R14 - 2048 khz transmit clock output, launch edge chosen by tx edge bit
// R15 - top address hex digit selects channel, zero selects shared bits
// R16 - receive line signals synchronised into sys_clk before use
`timescale 1ns/1ps
`default_nettype none
module e1li_line_if
  import e1li_pkg::*;
#(
  parameter logic [3:0] CH_NUM = 4'h1,
  parameter int unsigned CV_W = 16
)(
  input wire logic sys_clk, // system clock, 100 mhz
  input wire logic resetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb write
  input wire logic [15:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  output logic irq, // level interrupt, active high
  input wire logic rx_line_clock, // recovered 2048 khz receive clock
  input wire logic rx_pos_rail, // positive rail, or rx_nrz_data
  input wire logic rx_neg_rail, // negative rail, rx_ext_violation or rx_fast_sync_in
  output logic tx_line_clock, // generated 2048 khz transmit clock
  output logic tx_pos_rail, // positive rail, or tx_nrz_data
  output logic tx_neg_rail, // negative rail, tx_gp_output or tx_fast_sync_out
  output logic rx_valid, // pulse: new received bit on rx_bit
  output e1li_rails_t rx_bit, // received rails, nrz data on pos
  output logic rx_fs_pulse, // pulse: receive fast sync seen
  output logic tx_bit_req, // pulse: tx_bit taken, offer the next
  input wire e1li_rails_t tx_bit // bit to send, sys_clk domain
);

  if (CH_NUM < 4'h1 || CH_NUM > 4'h4)
    $error("CH_NUM must be 1 to 4");
  if (CV_W < 1 || CV_W > 32)
    $error("CV_W must be 1 to 32");

  // ----------------------------------------
  // configuration registers and apb slave
  // ----------------------------------------
  e1li_cfg_t cfg_q, cfg_d;
  logic [EV_W-1:0] stat_q, stat_d, mask_q, mask_d;
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pready_d, pslverr_q, pslverr_d, irq_q, irq_d;
  logic [CV_W-1:0] cv_q, cv_d;
  logic [EV_W-1:0] ev;
  logic [11:0] idx;
  logic own_ch, common, hit, setup, commit;

  assign idx = paddr[13:2];
  assign own_ch = idx[11:8] == CH_NUM; // see R15
  assign common = idx[11:8] == CH_COMMON; // see R15
  assign setup = psel && !penable;
  assign commit = psel && penable && pready_q;

  always_comb
  begin
    hit = 1'b1;
    prdata_d = prdata_q;
    if (own_ch && idx[7:0] == IDX_CTRL1[7:0])
      prdata_d = {24'h0, cfg_q.rail_mode, cfg_q.gp_output_value, 6'h0};
    else if (own_ch && idx[7:0] == IDX_CTRL2[7:0])
      prdata_d = {24'h0, cfg_q.tx_clock_edge_select, cfg_q.rx_clock_edge_select,
                  cfg_q.tx_nrz_invert, 4'h0, cfg_q.rx_nrz_invert};
    else if (own_ch && idx[7:0] == IDX_FSYNC[7:0])
      prdata_d = {30'h0, cfg_q.rx_fast_sync_enable, cfg_q.tx_fast_sync_enable};
    else if (own_ch && idx[7:0] == IDX_CVCNT[7:0])
      prdata_d = 32'(cv_q);
    else if (own_ch && idx[7:0] == IDX_STAT[7:0])
      prdata_d = 32'(stat_q);
    else if (own_ch && idx[7:0] == IDX_MASK[7:0])
      prdata_d = 32'(mask_q);
    else if (common && idx == IDX_ISUM)
      prdata_d = 32'(irq_q) << (CH_NUM - 4'h1);
    else
    begin
      hit = 1'b0;
      prdata_d = 32'h0;
    end
    if (!setup || pwrite)
      prdata_d = setup ? 32'h0 : prdata_q;
    pready_d = setup;
    pslverr_d = setup ? !hit : 1'b0;
  end

  always_comb
  begin
    cfg_d = cfg_q;
    mask_d = mask_q;
    if (commit && pwrite && !pslverr_q && own_ch)
    begin
      if (idx[7:0] == IDX_CTRL1[7:0])
      begin
        cfg_d.rail_mode = pwdata[B_RAIL];
        cfg_d.gp_output_value = pwdata[B_GP];
      end
      if (idx[7:0] == IDX_CTRL2[7:0])
      begin
        cfg_d.rx_nrz_invert = pwdata[B_RX_INV];
        cfg_d.tx_nrz_invert = pwdata[B_TX_INV];
        cfg_d.rx_clock_edge_select = pwdata[B_RX_EDGE];
        cfg_d.tx_clock_edge_select = pwdata[B_TX_EDGE];
      end
      if (idx[7:0] == IDX_FSYNC[7:0])
      begin
        cfg_d.rx_fast_sync_enable = pwdata[B_RX_FS];
        cfg_d.tx_fast_sync_enable = pwdata[B_TX_FS];
      end
      if (idx[7:0] == IDX_MASK[7:0])
        mask_d = pwdata[EV_W-1:0];
    end
    // a read clears status; an event in the same cycle survives
    stat_d = stat_q;
    if (commit && !pwrite && own_ch && idx[7:0] == IDX_STAT[7:0])
      stat_d = '0;
    stat_d = stat_d | ev;
    irq_d = |(stat_d & mask_d);
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cfg_q <= e1li_cfg_t'({CTRL1_RST[B_RAIL], CTRL1_RST[B_GP], CTRL2_RST[B_RX_INV],
                            CTRL2_RST[B_TX_INV], CTRL2_RST[B_RX_EDGE],
                            CTRL2_RST[B_TX_EDGE], FSYNC_RST[B_RX_FS],
                            FSYNC_RST[B_TX_FS]});
      mask_q <= MASK_RST;
      stat_q <= '0;
      irq_q <= 1'b0;
      prdata_q <= 32'h0;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end
    else
    begin
      cfg_q <= cfg_d;
      mask_q <= mask_d;
      stat_q <= stat_d;
      irq_q <= irq_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign irq = irq_q;

  // ----------------------------------------
  // receive side
  // ----------------------------------------
  // clock and data pass the same two stages, so their skew is kept
  logic [2:0] rclk_s_q, rclk_s_d;
  logic [1:0] rpos_s_q, rpos_s_d, rneg_s_q, rneg_s_d;
  logic rneg_prev_q, rneg_prev_d;
  logic rx_valid_q, rx_valid_d, rx_fs_q, rx_fs_d;
  e1li_rails_t rx_bit_q, rx_bit_d;
  logic r_rise, r_fall, r_take, nrz_mode, viol_hit;

  assign rclk_s_d = {rclk_s_q[1:0], rx_line_clock}; // see R16
  assign rpos_s_d = {rpos_s_q[0], rx_pos_rail}; // see R16
  assign rneg_s_d = {rneg_s_q[0], rx_neg_rail}; // see R16
  assign r_rise = rclk_s_q[1] && !rclk_s_q[2];
  assign r_fall = !rclk_s_q[1] && rclk_s_q[2];
  assign r_take = cfg_q.rx_clock_edge_select ? r_rise : r_fall; // see R8
  assign nrz_mode = !cfg_q.rail_mode;
  // violation is a rising-edge sample, counted once per line clock cycle
  assign viol_hit = nrz_mode && !cfg_q.rx_fast_sync_enable
                    && r_rise && rneg_s_q[1]; // see R5 R6

  always_comb
  begin
    rx_valid_d = r_take;
    rx_bit_d = rx_bit_q;
    rneg_prev_d = rneg_prev_q;
    if (r_take)
    begin
      if (cfg_q.rail_mode)
      begin
        rx_bit_d.pos = rpos_s_q[1]; // see R1
        rx_bit_d.neg = rneg_s_q[1]; // see R2
      end
      else
      begin
        rx_bit_d.pos = rpos_s_q[1] ^ cfg_q.rx_nrz_invert; // see R3 R4
        rx_bit_d.neg = 1'b0;
      end
      rneg_prev_d = rneg_s_q[1];
    end
    // fast sync marks multiframe bit 256 on the leading edge of its pulse
    rx_fs_d = nrz_mode && cfg_q.rx_fast_sync_enable && r_take
              && rneg_s_q[1] && !rneg_prev_q; // see R7
    cv_d = cv_q;
    if (viol_hit && cv_q != {CV_W{1'b1}})
      cv_d = cv_q + CV_W'(1); // see R5
    ev = '0;
    ev[EV_VIOL] = viol_hit;
    ev[EV_RX_FAST_SYNC_ENABLE] = rx_fs_d;
    ev[EV_CVSAT] = viol_hit && cv_q == {CV_W{1'b1}};
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rclk_s_q <= '0;
      rpos_s_q <= '0;
      rneg_s_q <= '0;
      rneg_prev_q <= 1'b0;
      rx_valid_q <= 1'b0;
      rx_bit_q <= '0;
      rx_fs_q <= 1'b0;
      cv_q <= '0;
    end
    else
    begin
      rclk_s_q <= rclk_s_d;
      rpos_s_q <= rpos_s_d;
      rneg_s_q <= rneg_s_d;
      rneg_prev_q <= rneg_prev_d;
      rx_valid_q <= rx_valid_d;
      rx_bit_q <= rx_bit_d;
      rx_fs_q <= rx_fs_d;
      cv_q <= cv_d;
    end
  end

  assign rx_valid = rx_valid_q;
  assign rx_bit = rx_bit_q;
  assign rx_fs_pulse = rx_fs_q;

  // ----------------------------------------
  // transmit side
  // ----------------------------------------
  // phase accumulator: 2048 khz is no integer divide of sys_clk, so edges
  // jitter by one sys_clk period; the truncated increment runs about 2.3 hz slow
  logic [ACC_W-1:0] acc_q, acc_d;
  logic [MF_CNT_W-1:0] tbit_q, tbit_d;
  logic tclk_q, tpos_q, tpos_d, tneg_q, tneg_d, treq_q, treq_d;
  logic t_rise, t_fall, t_launch;

  always_comb
  begin
    acc_d = acc_q + TX_ACC_INC;
    t_rise = !acc_q[ACC_W-1] && acc_d[ACC_W-1];
    t_fall = acc_q[ACC_W-1] && !acc_d[ACC_W-1];
    t_launch = cfg_q.tx_clock_edge_select ? t_rise : t_fall; // see R14
    tpos_d = tpos_q;
    tneg_d = tneg_q;
    tbit_d = tbit_q;
    treq_d = t_launch;
    if (t_launch)
    begin
      tbit_d = tbit_q + MF_CNT_W'(1);
      if (cfg_q.rail_mode)
      begin
        tpos_d = tx_bit.pos; // see R9
        tneg_d = tx_bit.neg; // see R10
      end
      else
      begin
        tpos_d = (tx_bit.pos | tx_bit.neg) ^ cfg_q.tx_nrz_invert; // see R11
        if (cfg_q.tx_fast_sync_enable)
          tneg_d = tbit_q == MF_CNT_W'(MF_BITS - 1); // see R13
      end
    end
    // general-purpose value always moves on the rising edge
    if (nrz_mode && !cfg_q.tx_fast_sync_enable && t_rise)
      tneg_d = cfg_q.gp_output_value; // see R12
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      acc_q <= '0;
      tclk_q <= 1'b0;
      tbit_q <= '0;
      tpos_q <= 1'b0;
      tneg_q <= 1'b0;
      treq_q <= 1'b0;
    end
    else
    begin
      acc_q <= acc_d;
      tclk_q <= acc_d[ACC_W-1]; // see R14
      tbit_q <= tbit_d;
      tpos_q <= tpos_d;
      tneg_q <= tneg_d;
      treq_q <= treq_d;
    end
  end

  assign tx_line_clock = tclk_q;
  assign tx_pos_rail = tpos_q;
  assign tx_neg_rail = tneg_q;
  assign tx_bit_req = treq_q;

  // helper: cycles that the transmit clock has held its level; bounds the
  // half period from above, tx_clk_a bounds the high half from below
  localparam int unsigned HALF_MAX = ((1 << (ACC_W - 1)) + TX_ACC_INC - 1) / TX_ACC_INC;
  logic [5:0] thalf_q, thalf_d;

  always_comb
  begin
    thalf_d = thalf_q + 6'h1;
    if (tclk_q != acc_d[ACC_W-1])
      thalf_d = '0;
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      thalf_q <= '0;
    else
      thalf_q <= thalf_d;
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  rail_rx_pos_a: assert property (r_take && cfg_q.rail_mode |=> rx_valid && rx_bit.pos == $past(rpos_s_q[1])) // see R1
    else $error("rail mode positive rail not passed");
  rail_rx_neg_a: assert property (r_take && cfg_q.rail_mode |=> rx_bit.neg == $past(rneg_s_q[1])) // see R2
    else $error("rail mode negative rail not passed");
  nrz_rx_data_a: assert property (r_take && nrz_mode |=> rx_bit.pos == ($past(rpos_s_q[1]) ^ $past(cfg_q.rx_nrz_invert)) && !rx_bit.neg) // see R3 R4
    else $error("nrz receive data wrong polarity");
  viol_count_a: assert property (viol_hit && cv_q != {CV_W{1'b1}} |=> cv_q == $past(cv_q) + CV_W'(1)) // see R5 R6
    else $error("violation not counted");
  no_count_a: assert property (!viol_hit |=> cv_q == $past(cv_q)) // see R5
    else $error("counter moved without violation");
  rx_fs_mode_a: assert property (rx_fs_pulse |-> $past(!cfg_q.rail_mode && cfg_q.rx_fast_sync_enable)) // see R7
    else $error("fast sync pulse outside its mode");
  rx_edge_a: assert property (rx_valid |-> $past(cfg_q.rx_clock_edge_select) == $past(rclk_s_q[1])) // see R8
    else $error("receive sampled on wrong edge");
  tx_nrz_a: assert property (t_launch && nrz_mode |=> tx_pos_rail == ($past(tx_bit.pos | tx_bit.neg) ^ $past(cfg_q.tx_nrz_invert))) // see R11
    else $error("nrz transmit data wrong");
  tx_rails_a: assert property (t_launch && cfg_q.rail_mode |=> tx_pos_rail == $past(tx_bit.pos) && tx_neg_rail == $past(tx_bit.neg)) // see R9 R10
    else $error("transmit rails wrong");
  tx_gp_a: assert property (nrz_mode && !cfg_q.tx_fast_sync_enable && t_rise ##1 $stable(cfg_q) |-> tx_neg_rail == cfg_q.gp_output_value) // see R12
    else $error("general purpose output not shifted out");
  tx_fs_a: assert property (t_launch && nrz_mode && cfg_q.tx_fast_sync_enable && tbit_q == MF_CNT_W'(MF_BITS - 1) |=> tx_neg_rail) // see R13
    else $error("transmit fast sync pulse missing");
  tx_clk_a: assert property ($rose(tx_line_clock) |-> tx_line_clock [*8]) // see R14
    else $error("transmit clock half period too short");
  tx_half_max_a: assert property (thalf_q < 6'(HALF_MAX)) // see R14
    else $error("transmit clock half period too long");
  dec_err_a: assert property (setup && !own_ch && !common |=> pready && pslverr) // see R15
    else $error("unmapped address accepted");

  viol_seen_c: cover property (viol_hit);
  rx_fs_seen_c: cover property (rx_fs_pulse);
  tx_fs_seen_c: cover property (t_launch && tbit_q == MF_CNT_W'(MF_BITS - 1));
  irq_seen_c: cover property ($rose(irq));

endmodule : e1li_line_if
`default_nettype wire

//--- hdl/e1li_pkg.sv
// e1li_pkg: constants and types for the e1 line-side interface
`default_nettype none
package e1li_pkg;
  // clock rates and link timing
  localparam int unsigned SYS_CLK_KHZ = 100000;
  localparam int unsigned LINE_CLK_KHZ = 2048;
  localparam int unsigned TX_FS_PERIOD_MS = 2;
  localparam int unsigned MF_BITS = LINE_CLK_KHZ * TX_FS_PERIOD_MS;
  localparam int unsigned MF_CNT_W = $clog2(MF_BITS);
  localparam int unsigned ACC_W = 24;
  localparam logic [ACC_W-1:0] TX_ACC_INC =
    ACC_W'((64'(LINE_CLK_KHZ) << ACC_W) / 64'(SYS_CLK_KHZ));

  // register indices; byte address is four times the index
  localparam logic [11:0] IDX_CTRL1 = 12'h000;
  localparam logic [11:0] IDX_CTRL2 = 12'h001;
  localparam logic [11:0] IDX_FSYNC = 12'h006;
  localparam logic [11:0] IDX_CVCNT = 12'h010;
  localparam logic [11:0] IDX_STAT = 12'h011;
  localparam logic [11:0] IDX_MASK = 12'h012;
  localparam logic [11:0] IDX_ISUM = 12'h00e;
  localparam logic [3:0] CH_COMMON = 4'h0;

  // field positions
  localparam int unsigned B_RAIL = 7;
  localparam int unsigned B_GP = 6;
  localparam int unsigned B_RX_INV = 0;
  localparam int unsigned B_TX_INV = 5;
  localparam int unsigned B_RX_EDGE = 6;
  localparam int unsigned B_TX_EDGE = 7;
  localparam int unsigned B_TX_FS = 0;
  localparam int unsigned B_RX_FS = 1;
  localparam int unsigned EV_W = 3;
  localparam int unsigned EV_VIOL = 0;
  localparam int unsigned EV_RX_FAST_SYNC_ENABLE = 1;
  localparam int unsigned EV_CVSAT = 2;

  // reset values
  localparam logic [7:0] CTRL1_RST = 8'h80;
  localparam logic [7:0] CTRL2_RST = 8'hc0;
  localparam logic [7:0] FSYNC_RST = 8'h00;
  localparam logic [EV_W-1:0] MASK_RST = 3'h0;

  typedef struct packed {
    logic rail_mode;
    logic gp_output_value;
    logic rx_nrz_invert;
    logic tx_nrz_invert;
    logic rx_clock_edge_select;
    logic tx_clock_edge_select;
    logic rx_fast_sync_enable;
    logic tx_fast_sync_enable;
  } e1li_cfg_t;

  typedef struct packed {
    logic pos;
    logic neg;
  } e1li_rails_t;
endpackage : e1li_pkg
`default_nettype wire
